// *** include/pmc_cfg.svh ***
// constants for the processor mode control block
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define RST_EDGES 3'd5
`define PC_RESET 32'h00000000
`define NPC_RESET 32'h00000004
`define PC_STEP 32'h00000004
`define TT_FP_EXC 8'h08
`define TT_RF_ERR 8'h20
`define TT_WIN_OVF 8'h05
`define TT_WIN_UNF 8'h06
`define FIX_CYCLES 3'd4
`define IRQ_TOP 4'hF
`define AREA_IO 4'h2
`define AREA_RAM 4'h4
`define AREA_REG 4'h8
`define AREA_DSU 4'h9
`define AREA_PCI 4'hA
`define R_PSW 8'h00
`define R_Y 8'h04
`define R_IDLE 8'h08
`define R_WIM 8'h0C
`define R_WPROT 8'h10
`define R_FSR 8'h14
`define R_TT 8'h18
`define R_PC 8'h1C
`define PSW_CWP 2:0
`define PSW_ET 5
`define PSW_S 7
`define PSW_PIL 11:8
`define FSR_QNE 13
`define TT_MODE 10:8
`endif

// *** include/pmc_pkg.sv ***
// types for the processor mode control block
package pmc_pkg;
  typedef enum logic [2:0] {M_RESET, M_EXEC, M_ERROR, M_IDLE, M_DEBUG} mode_t;
  typedef enum logic [1:0] {OP_UMUL, OP_SMUL, OP_UDIV, OP_SDIV} op_t;
  typedef struct packed {
    mode_t mode;
    logic [2:0] rst_cnt;
    logic [2:0] fix_cnt;
    logic [31:0] pc;
    logic [31:0] npc;
    logic et;
    logic s;
    logic [3:0] pil;
    logic [2:0] cwp;
    logic [7:0] window_invalid_mask;
    logic idle_arm;
    logic [5:0] wprot;
    logic [3:0] icc;
    logic [31:0] rdata;
    logic sd_q;
    logic trap_p;
    logic irq_p;
    logic [3:0] irq_lvl;
    logic [31:0] mdu_res;
    logic mdu_v;
    logic [63:0] rf_data;
    logic rf_v;
    logic [5:0] area;
    logic acc_err;
  } state_t;
  typedef struct packed {
    logic [7:0] tt;
    logic [31:0] y;
    logic [31:0][38:0] fpr;
  } keep_t;
endpackage

// *** verilog/processor_mode_control.sv ***
// processor mode, trap, arithmetic and fault handling control
`timescale 1ns/1ps
`include "pmc_cfg.svh"
// What this block does
// - multiply gives full product, upper half to Y
// - only cc variants update condition codes
// - divide 64 by 32 with overflow saturation
// - pipeline stalls during floating-point execution
// - queue bit reads zero; queue store traps
// - 32 float registers, doubles use even-odd pairs
// - address space decodes into six areas
// - all areas accessible unless write protected
// - control registers triplicated and majority voted, except trap type and Y
// - seven check bits per register, checked on use
// - correctable error fixed, written back, four cycles
// - uncorrectable register error raises trap 0x20
// - cache parity error treated as miss
// - reset enters async, exits fifth sdram edge
// - reset halts units, clears traps, pc zero
// - trap with traps disabled enters error mode
// - error mode left only by reset, data kept
// - idle register write arms idle at load
// - enabled interrupt above level ends idle
// - debug unit enable and break hold pipeline
// - window save/restore into invalid window traps
module processor_mode_control (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic sdram_clock_in,
  input wire logic debug_unit_enable_in,
  input wire logic debug_break_request_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic instr_done_in,
  input wire logic load_in,
  input wire logic trap_req_in,
  input wire logic [7:0] trap_type_in,
  input wire logic stdfq_in,
  input wire logic save_in,
  input wire logic restore_in,
  input wire logic fp_busy_in,
  input wire logic [15:0] irq_pending_in,
  input wire logic [15:0] irq_mask_in,
  input wire logic mdu_start_in,
  input wire pmc_pkg::op_t mdu_op_in,
  input wire logic mdu_cc_in,
  input wire logic [31:0] mdu_a_in,
  input wire logic [31:0] mdu_b_in,
  output logic [31:0] mdu_result_out,
  output logic mdu_valid_out,
  output logic [3:0] icc_out,
  input wire logic rf_wr_in,
  input wire logic [4:0] rf_wr_idx_in,
  input wire logic [31:0] rf_wr_data_in,
  input wire logic rf_rd_in,
  input wire logic rf_rd_dbl_in,
  input wire logic [4:0] rf_rd_idx_in,
  output logic [63:0] rf_rd_data_out,
  output logic rf_rd_valid_out,
  input wire logic [31:0] bus_addr_in,
  input wire logic bus_wr_in,
  output logic [5:0] area_out,
  output logic access_err_out,
  input wire logic cache_hit_in,
  input wire logic cache_parity_err_in,
  output logic cache_hit_out,
  output logic cache_refill_out,
  output pmc_pkg::mode_t mode_out,
  output logic [31:0] pc_out,
  output logic [31:0] npc_out,
  output logic fetch_en_out,
  output logic stall_out,
  output logic pipe_hold_out,
  output logic periph_halt_out,
  output logic error_n_out,
  output logic trap_taken_out,
  output logic [7:0] trap_type_out,
  output logic irq_service_out,
  output logic [3:0] irq_level_out
);
  import pmc_pkg::*;

  logic rs1_r, rs2_r, rst_n;
  logic [2:0] sy1_r, sy2_r;
  state_t st_r [3];
  state_t st, st_nxt;
  keep_t kp_r, kp_nxt;
  logic [33:0] dec_a, dec_b;
  logic [63:0] sprod, uprod, sq, uq;
  logic [31:0] res, q;
  logic ovf, fire, sd_rise, wake;
  logic [7:0] tt;
  logic [2:0] cwp_n;
  logic [15:0] lvl_ok;
  logic [4:0] ia, ib;

  function automatic logic [38:0] ecc_enc(input logic [31:0] d);
    logic [38:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int i = 0; i < 6; i++) begin
      for (int p = 3; p < 39; p++) begin
        if (p[i] && (p & (p - 1)) != 0) c[1 << i] = c[1 << i] ^ c[p];
      end
    end
    c[0] = ^c[38:1];
    return c;
  endfunction

  // returns {uncorrectable, corrected, data}
  function automatic logic [33:0] ecc_dec(input logic [38:0] c);
    logic [5:0] s;
    logic [38:0] f;
    logic [31:0] d;
    logic unc;
    int k;
    s = '0;
    f = c;
    d = '0;
    k = 0;
    for (int i = 0; i < 6; i++) begin
      for (int p = 1; p < 39; p++) begin
        if (p[i]) s[i] = s[i] ^ c[p];
      end
    end
    unc = (s != '0) && (!(^c) || s > 6'd38);
    if (!unc && (^c)) f[s] = ~f[s];
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = f[p];
        k++;
      end
    end
    return {unc, (^c) && !unc, d};
  endfunction

  // reset release through two stages, assertion stays asynchronous
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_n = rs2_r;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= 3'h0;
      sy2_r <= 3'h0;
    end else begin
      sy1_r <= {debug_break_request_in, debug_unit_enable_in, sdram_clock_in};
      sy2_r <= sy1_r;
    end
  end

  // three voted copies of the control state
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : tmr
      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          st_r[g] <= '0;
          st_r[g].mode <= M_RESET;
          st_r[g].pc <= `PC_RESET;
          st_r[g].npc <= `NPC_RESET;
          st_r[g].s <= 1'b1;
        end else begin
          st_r[g] <= st_nxt;
        end
      end
    end
  endgenerate
  assign st = state_t'((st_r[0] & st_r[1]) | (st_r[0] & st_r[2]) | (st_r[1] & st_r[2]));

  // trap type and data survive reset
  always_ff @(posedge core_clk_in) begin
    kp_r <= kp_nxt;
  end

  generate
    for (g = 0; g < 16; g++) begin : lvl
      assign lvl_ok[g] = (4'(g) == `IRQ_TOP) || (4'(g) > st.pil);
    end
  endgenerate

  always_comb begin
    st_nxt = st;
    kp_nxt = kp_r;
    st_nxt.trap_p = 1'b0;
    st_nxt.irq_p = 1'b0;
    st_nxt.mdu_v = 1'b0;
    st_nxt.rf_v = 1'b0;
    st_nxt.rdata = '0;
    sd_rise = sy2_r[0] && !st.sd_q;
    st_nxt.sd_q = sy2_r[0];
    sprod = $signed(mdu_a_in) * $signed(mdu_b_in);
    uprod = {32'h0, mdu_a_in} * {32'h0, mdu_b_in};
    uq = (mdu_b_in == '0) ? '1 : {kp_r.y, mdu_a_in} / {32'h0, mdu_b_in};
    sq = (mdu_b_in == '0) ? 64'sh7FFFFFFF : $signed({kp_r.y, mdu_a_in}) / $signed({{32{mdu_b_in[31]}}, mdu_b_in});
    if (mdu_op_in == OP_UDIV) begin
      ovf = |uq[63:32];
      q = ovf ? 32'hFFFFFFFF : uq[31:0];
    end else begin
      ovf = ($signed(sq) > 64'sh7FFFFFFF) || ($signed(sq) < -64'sh80000000);
      q = ovf ? (sq[63] ? 32'h80000000 : 32'h7FFFFFFF) : sq[31:0];
    end
    res = (mdu_op_in == OP_SMUL) ? sprod[31:0] : (mdu_op_in == OP_UMUL) ? uprod[31:0] : q;
    // register file read with check and repair
    ia = rf_rd_dbl_in ? {rf_rd_idx_in[4:1], 1'b0} : rf_rd_idx_in;
    ib = {rf_rd_idx_in[4:1], 1'b1};
    dec_a = ecc_dec(kp_r.fpr[ia]);
    dec_b = rf_rd_dbl_in ? ecc_dec(kp_r.fpr[ib]) : 34'h0;
    // trap sources by priority
    cwp_n = save_in ? st.cwp - 3'd1 : st.cwp + 3'd1;
    fire = 1'b1;
    if (rf_rd_in && st.fix_cnt == '0 && (dec_a[33] || dec_b[33])) tt = `TT_RF_ERR;
    else if (stdfq_in) tt = `TT_FP_EXC;
    else if (save_in && st.window_invalid_mask[cwp_n]) tt = `TT_WIN_OVF;
    else if (restore_in && st.window_invalid_mask[cwp_n]) tt = `TT_WIN_UNF;
    else begin
      tt = trap_type_in;
      fire = trap_req_in;
    end
    wake = |(irq_pending_in & irq_mask_in & lvl_ok);
    st_nxt.area = 6'h0;
    if (bus_addr_in[31:28] < `AREA_IO) st_nxt.area[0] = 1'b1;
    else if (bus_addr_in[31:28] < `AREA_RAM) st_nxt.area[1] = 1'b1;
    else if (bus_addr_in[31:28] < `AREA_REG) st_nxt.area[2] = 1'b1;
    else if (bus_addr_in[31:28] == `AREA_REG) st_nxt.area[3] = 1'b1;
    else if (bus_addr_in[31:28] == `AREA_DSU) st_nxt.area[4] = 1'b1;
    else st_nxt.area[5] = 1'b1;
    st_nxt.acc_err = bus_wr_in && |(st_nxt.area & st.wprot);
    case (st.mode)
      M_RESET: begin
        st_nxt.pc = `PC_RESET;
        st_nxt.npc = `NPC_RESET;
        st_nxt.et = 1'b0;
        st_nxt.s = 1'b1;
        if (sd_rise) st_nxt.rst_cnt = st.rst_cnt + 3'd1;
        if (sd_rise && st.rst_cnt == `RST_EDGES - 3'd1) st_nxt.mode = M_EXEC;
      end
      M_EXEC: begin
        if (instr_done_in && st.fix_cnt == '0) begin
          st_nxt.pc = st.npc;
          st_nxt.npc = st.npc + `PC_STEP;
        end
        if ((save_in || restore_in) && !st.window_invalid_mask[cwp_n]) st_nxt.cwp = cwp_n;
        if (fire) begin
          kp_nxt.tt = tt;
          if (st.et) begin
            st_nxt.et = 1'b0;
            st_nxt.s = 1'b1;
            st_nxt.trap_p = 1'b1;
          end else begin
            st_nxt.mode = M_ERROR;
          end
        end else if (load_in && st.idle_arm) begin
          st_nxt.mode = M_IDLE;
          st_nxt.idle_arm = 1'b0;
        end
      end
      M_IDLE: begin
        if (wake) begin
          st_nxt.mode = M_EXEC;
          st_nxt.irq_p = 1'b1;
          for (int l = 1; l < 16; l++) begin
            if (irq_pending_in[l] && irq_mask_in[l] && lvl_ok[l]) st_nxt.irq_lvl = 4'(l);
          end
        end
      end
      M_DEBUG: begin
        if (!sy2_r[2]) st_nxt.mode = M_EXEC;
      end
      default: begin
        st_nxt.mode = M_ERROR;
      end
    endcase
    if ((st.mode == M_EXEC || st.mode == M_IDLE) && sy2_r[1] && sy2_r[2]) st_nxt.mode = M_DEBUG;
    // multiply and divide
    if (mdu_start_in && st.mode == M_EXEC) begin
      st_nxt.mdu_res = res;
      st_nxt.mdu_v = 1'b1;
      if (mdu_op_in == OP_SMUL) kp_nxt.y = sprod[63:32];
      if (mdu_op_in == OP_UMUL) kp_nxt.y = uprod[63:32];
      if (mdu_cc_in) st_nxt.icc = {res[31], res == '0, ovf && mdu_op_in[1], 1'b0};
    end
    if (st.fix_cnt != '0) begin
      st_nxt.fix_cnt = st.fix_cnt - 3'd1;
      st_nxt.rf_v = st.fix_cnt == 3'd1;
    end else if (rf_rd_in && !dec_a[33] && !dec_b[33]) begin
      st_nxt.rf_data = rf_rd_dbl_in ? {dec_a[31:0], dec_b[31:0]} : {32'h0, dec_a[31:0]};
      if (dec_a[32] || dec_b[32]) begin
        st_nxt.fix_cnt = `FIX_CYCLES;
        kp_nxt.fpr[ia] = ecc_enc(dec_a[31:0]);
        if (rf_rd_dbl_in) kp_nxt.fpr[ib] = ecc_enc(dec_b[31:0]);
      end else begin
        st_nxt.rf_v = 1'b1;
      end
    end
    if (rf_wr_in) kp_nxt.fpr[rf_wr_idx_in] = ecc_enc(rf_wr_data_in);
    // register port
    if (reg_wr_in) begin
      case (reg_addr_in)
        `R_PSW: begin
          st_nxt.et = reg_wdata_in[`PSW_ET];
          st_nxt.s = reg_wdata_in[`PSW_S];
          st_nxt.pil = reg_wdata_in[`PSW_PIL];
          st_nxt.cwp = reg_wdata_in[`PSW_CWP];
        end
        `R_Y: kp_nxt.y = reg_wdata_in;
        `R_IDLE: st_nxt.idle_arm = 1'b1;
        `R_WIM: st_nxt.window_invalid_mask = reg_wdata_in[7:0];
        `R_WPROT: st_nxt.wprot = reg_wdata_in[5:0];
        default: st_nxt.idle_arm = st_nxt.idle_arm;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `R_PSW: begin
          st_nxt.rdata[`PSW_ET] = st.et;
          st_nxt.rdata[`PSW_S] = st.s;
          st_nxt.rdata[`PSW_PIL] = st.pil;
          st_nxt.rdata[`PSW_CWP] = st.cwp;
        end
        `R_Y: st_nxt.rdata = kp_r.y;
        `R_WIM: st_nxt.rdata[7:0] = st.window_invalid_mask;
        `R_WPROT: st_nxt.rdata[5:0] = st.wprot;
        `R_FSR: st_nxt.rdata[`FSR_QNE] = 1'b0;
        `R_TT: st_nxt.rdata = {21'h0, st.mode, kp_r.tt};
        `R_PC: st_nxt.rdata = st.pc;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  assign reg_rdata_out = st.rdata;
  assign mdu_result_out = st.mdu_res;
  assign mdu_valid_out = st.mdu_v;
  assign icc_out = st.icc;
  assign rf_rd_data_out = st.rf_data;
  assign rf_rd_valid_out = st.rf_v;
  assign area_out = st.area;
  assign access_err_out = st.acc_err;
  assign cache_hit_out = cache_hit_in && !cache_parity_err_in;
  assign cache_refill_out = cache_parity_err_in;
  assign mode_out = st.mode;
  assign pc_out = st.pc;
  assign npc_out = st.npc;
  assign stall_out = fp_busy_in || st.fix_cnt != '0;
  assign fetch_en_out = st.mode == M_EXEC && !stall_out;
  assign pipe_hold_out = st.mode != M_EXEC;
  assign periph_halt_out = st.mode == M_RESET;
  assign error_n_out = st.mode != M_ERROR;
  assign trap_taken_out = st.trap_p;
  assign trap_type_out = kp_r.tt;
  assign irq_service_out = st.irq_p;
  assign irq_level_out = st.irq_lvl;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);
  property p_rst_pc;
    st.mode == M_RESET |-> st.pc == `PC_RESET && st.npc == `NPC_RESET && !st.et && st.s;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("reset state wrong");
  property p_err_stay;
    st.mode == M_ERROR |=> st.mode == M_ERROR && !error_n_out;
  endproperty
  a_err_stay: assert property (p_err_stay) else $error("error mode left");
  property p_trap_err;
    st.mode == M_EXEC && fire && !st.et |=> st.mode == M_ERROR && kp_r.tt == $past(tt);
  endproperty
  a_trap_err: assert property (p_trap_err) else $error("no error mode");
  property p_fix;
    $rose(st.fix_cnt == `FIX_CYCLES) |-> stall_out [*4] ##0 !rf_rd_valid_out ##1 rf_rd_valid_out;
  endproperty
  a_fix: assert property (p_fix) else $error("repair timing wrong");
  property p_fp_stall;
    fp_busy_in |-> stall_out && !fetch_en_out;
  endproperty
  a_fp_stall: assert property (p_fp_stall) else $error("no fp stall");
  property p_mul_y;
    mdu_start_in && st.mode == M_EXEC && mdu_op_in == OP_UMUL |=> kp_r.y == $past(uprod[63:32]);
  endproperty
  a_mul_y: assert property (p_mul_y) else $error("y not loaded");
  property p_plain_cc;
    mdu_start_in && !mdu_cc_in |=> icc_out == $past(icc_out);
  endproperty
  a_plain_cc: assert property (p_plain_cc) else $error("icc changed");
  property p_cache;
    cache_parity_err_in |-> !cache_hit_out && cache_refill_out;
  endproperty
  a_cache: assert property (p_cache) else $error("parity hit kept");
  property p_idle;
    st.mode == M_IDLE && !wake && !sy2_r[2] |=> st.mode == M_IDLE && !fetch_en_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle left early");
endmodule

// *** tb/sys_reset_model.sv ***
// system reset logic and debug unit stand-in
`timescale 1ns/1ps
module sys_reset_model (
  input wire logic rst_req_in,
  input wire logic brk_req_in,
  output logic rst_n_out,
  output logic sdram_clk_out,
  output logic dbg_en_out,
  output logic dbg_brk_out
);
  // memory clock runs free, unrelated to the core clock
  initial begin
    sdram_clk_out = 1'h0;
    #1.3;
    forever #5 sdram_clk_out = ~sdram_clk_out;
  end
  // reset level follows the request at once
  assign rst_n_out = ~rst_req_in;
  // debug pins stay low unless a session is asked for
  assign dbg_en_out = brk_req_in;
  assign dbg_brk_out = brk_req_in;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the processor mode control block
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module testbench;
  import pmc_pkg::*;
  logic clk, rst_req, brk_req, rst_n, sdram_clock, dben, dbbrk;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, ma, mb, mres, rfwd, baddr, pc, npc, d;
  logic wr_s, rd_s, idone, ld, stq, fpb, mst, mcc, mdu_v, rfw, rfr, rfd, rf_v;
  logic bwr, chit, cperr, acc_err, hit_o, refill, fetch_en, stall, hold, phalt, err_n, irq_svc;
  logic [15:0] ipend, imask;
  logic sv, rs, treq, ttk;
  logic [7:0] ttype, tto;
  logic [4:0] rfwi, rfri;
  logic [63:0] rf_data;
  logic [5:0] area;
  logic [3:0] icc, irq_lvl;
  logic [31:0] at [6];
  op_t mop;
  mode_t mode;
  int failures, samples_checked;

  sys_reset_model sys_reset_model_inst (.rst_req_in(rst_req), .brk_req_in(brk_req), .rst_n_out(rst_n),
    .sdram_clk_out(sdram_clock), .dbg_en_out(dben), .dbg_brk_out(dbbrk));

  processor_mode_control processor_mode_control_inst (.core_clk_in(clk), .rst_n_in(rst_n),
    .sdram_clock_in(sdram_clock), .debug_unit_enable_in(dben), .debug_break_request_in(dbbrk),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .instr_done_in(idone), .load_in(ld), .trap_req_in(treq), .trap_type_in(ttype), .stdfq_in(stq),
    .save_in(sv), .restore_in(rs), .fp_busy_in(fpb), .irq_pending_in(ipend), .irq_mask_in(imask),
    .mdu_start_in(mst), .mdu_op_in(mop), .mdu_cc_in(mcc), .mdu_a_in(ma), .mdu_b_in(mb),
    .mdu_result_out(mres), .mdu_valid_out(mdu_v), .icc_out(icc), .rf_wr_in(rfw), .rf_wr_idx_in(rfwi),
    .rf_wr_data_in(rfwd), .rf_rd_in(rfr), .rf_rd_dbl_in(rfd), .rf_rd_idx_in(rfri),
    .rf_rd_data_out(rf_data), .rf_rd_valid_out(rf_v), .bus_addr_in(baddr), .bus_wr_in(bwr),
    .area_out(area), .access_err_out(acc_err), .cache_hit_in(chit), .cache_parity_err_in(cperr),
    .cache_hit_out(hit_o), .cache_refill_out(refill), .mode_out(mode), .pc_out(pc), .npc_out(npc),
    .fetch_en_out(fetch_en), .stall_out(stall), .pipe_hold_out(hold), .periph_halt_out(phalt),
    .error_n_out(err_n), .trap_taken_out(ttk), .trap_type_out(tto), .irq_service_out(irq_svc),
    .irq_level_out(irq_lvl));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 v = rdata;
  endtask

  // one-cycle strobes: 0 done, 1 load, 2 queue store, 3 mdu, 4 rf write, 5 rf read, 6 save, 7 restore, 8 trap
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: idone <= 1'h1;
      1: ld <= 1'h1;
      2: stq <= 1'h1;
      3: mst <= 1'h1;
      4: rfw <= 1'h1;
      5: rfr <= 1'h1;
      6: sv <= 1'h1;
      7: rs <= 1'h1;
      default: treq <= 1'h1;
    endcase
    @(posedge clk);
    {idone, ld, stq, mst, rfw, rfr, sv, rs, treq} <= 9'h000;
  endtask

  function automatic logic hit(input int w);
    case (w)
      0: return mdu_v === 1'h1;
      1: return irq_svc === 1'h1;
      2: return rf_v === 1'h1;
      default: return mode === mode_t'(w - 3);
    endcase
  endfunction

  task automatic wait_for(input int w);
    int i;
    i = 0;
    #1;
    while (!hit(w) && i < 200) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (!hit(w)) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'h0, 1'h1);
      stop_test();
    end
  endtask

  task automatic mdu(input op_t op, input logic cc, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] exp);
    mop <= op;
    mcc <= cc;
    ma <= a;
    mb <= b;
    pulse(3);
    wait_for(0);
    chk(mres, exp);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_req <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk(mode, M_RESET);
    chk({pc, npc}, {`PC_RESET, `NPC_RESET});
    chk({err_n, phalt, hold, fetch_en}, 4'hE);
    @(posedge clk);
    rst_req <= 1'h0;
    repeat (3) @(posedge clk);
    #1 chk(mode, M_RESET);
    wait_for(3 + M_EXEC);
  endtask

  initial begin
    {addr, wdata, wr_s, rd_s, idone, ld, stq, fpb, ipend, imask, mst, mcc, ma, mb} = '0;
    {rfw, rfwi, rfwd, rfr, rfd, rfri, baddr, bwr, chit, cperr, brk_req} = '0;
    {sv, rs, treq, ttype} = '0;
    mop = OP_UMUL;
    rst_req = 1'h1;
    failures = 0;
    samples_checked = 0;
    at = '{32'h00000000, 32'h20000000, 32'h40000000, 32'h80000000, 32'h90000000, 32'hA0000000};
    do_reset();
    rd(`R_PSW, d);
    chk({d[`PSW_S], d[`PSW_ET]}, 2'h2);
    rd(`R_FSR, d);
    chk(d, 32'h00000000);
    pulse(0);
    #1 chk({pc, npc}, {`NPC_RESET, `NPC_RESET + `PC_STEP});
    $display("test reset done");
    mdu(OP_UMUL, 1'h1, 32'hFFFFFFFF, 32'h00000002, 32'hFFFFFFFE);
    chk(icc, 4'h8);
    rd(`R_Y, d);
    chk(d, 32'h00000001);
    mdu(OP_SMUL, 1'h0, 32'h00000000, 32'h00000005, 32'h00000000);
    chk(icc, 4'h8);
    mdu(OP_SMUL, 1'h0, 32'hFFFFFFFF, 32'h00000002, 32'hFFFFFFFE);
    rd(`R_Y, d);
    chk(d, 32'hFFFFFFFF);
    mdu(OP_SDIV, 1'h1, 32'hFFFFFFF8, 32'h00000002, 32'hFFFFFFFC);
    chk(icc, 4'h8);
    wr(`R_Y, 32'h00000001);
    mdu(OP_UDIV, 1'h0, 32'h00000000, 32'h00000004, 32'h40000000);
    $display("test arithmetic done");
    fpb <= 1'h1;
    chit <= 1'h1;
    cperr <= 1'h1;
    @(posedge clk);
    #1 chk(stall, 1'h1);
    chk({hit_o, refill}, 2'h1);
    {fpb, chit, cperr} <= 3'h0;
    rfwi <= 5'h02;
    rfwd <= 32'h12345678;
    pulse(4);
    rfwi <= 5'h03;
    rfwd <= 32'h9ABCDEF0;
    pulse(4);
    rfri <= 5'h02;
    rfd <= 1'h1;
    pulse(5);
    wait_for(2);
    chk(rf_data, 64'h123456789ABCDEF0);
    $display("test stall and files done");
    for (int i = 0; i < 6; i++) begin
      baddr <= at[i];
      repeat (2) @(posedge clk);
      #1 chk(area, 6'h01 << i);
    end
    wr(`R_WPROT, 32'h00000004);
    bwr <= 1'h1;
    baddr <= 32'h40000000;
    repeat (2) @(posedge clk);
    #1 chk(acc_err, 1'h1);
    baddr <= 32'h20000000;
    repeat (2) @(posedge clk);
    #1 chk(acc_err, 1'h0);
    bwr <= 1'h0;
    $display("test decode done");
    wr(`R_WIM, 32'h00000080);
    wr(`R_PSW, 32'h000000A0);
    pulse(6);
    #1 chk({ttk, tto}, {1'h1, `TT_WIN_OVF});
    pulse(7);
    rd(`R_PSW, d);
    chk({d[`PSW_S], d[`PSW_ET], d[`PSW_CWP]}, 5'h11);
    wr(`R_PSW, 32'h000000A1);
    ttype <= 8'h11;
    pulse(8);
    #1 chk({ttk, tto, mode}, {1'h1, 8'h11, M_EXEC});
    @(posedge clk);
    #1 chk(ttk, 1'h0);
    $display("test traps done");
    wr(`R_IDLE, 32'h0000005A);
    pulse(1);
    wait_for(3 + M_IDLE);
    chk(fetch_en, 1'h0);
    imask <= 16'hFFFF;
    ipend <= 16'h8000;
    wait_for(1);
    chk(irq_lvl, `IRQ_TOP);
    wait_for(3 + M_EXEC);
    ipend <= 16'h0000;
    brk_req <= 1'h1;
    wait_for(3 + M_DEBUG);
    chk(hold, 1'h1);
    brk_req <= 1'h0;
    wait_for(3 + M_EXEC);
    $display("test idle and debug done");
    pulse(2);
    wait_for(3 + M_ERROR);
    repeat (20) @(posedge clk);
    #1 chk(mode, M_ERROR);
    chk(err_n, 1'h0);
    rd(`R_TT, d);
    chk(d[7:0], `TT_FP_EXC);
    do_reset();
    rd(`R_TT, d);
    chk(d[7:0], `TT_FP_EXC);
    $display("test error mode done");
    stop_test();
  end
endmodule
